/* bench/autoreclose_sequencer_bench.sv */
// Purpose: Self-checking bench for the autoreclose sequencer.
// Assumes: A tick of four clocks; the breaker model answers trips and closes.
// Notes: The shot-one dead time and the reclaim time are written small to keep the run short.
`timescale 1ns/1ps
`default_nettype none
module autoreclose_sequencer_bench;
    localparam int TK = 4;
    logic clk, rst_b, psel, penable, pwrite, pready, serr, trip, en, insvc, ld, sc, hl, lo, rx, tp, arc, pfi, sci;
    logic ac, hold, prog, ok;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [2:0] pole, shot, fp;
    logic [4:0] ss, ss_seen;
    int err_count, checks_done, n, dead;
    autoreclose_sequencer #(.TICK_CYCLES(TK)) autoreclose_sequencer_inst (
        .i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(serr),
        .i_prot_trip(trip), .i_ar_enable(en), .i_cb_in_service(insvc), .i_pole_open(pole),
        .i_line_dead(ld), .i_system_check_ok(sc), .i_cb_healthy(hl), .i_lockout(lo),
        .i_reclaim_extend(rx), .i_three_phase_trip(tp), .i_faulted_phase(fp), .i_arc_extinct(arc),
        .i_permanent_fault(pfi), .i_success_clear_input(sci), .o_autoclose(ac),
        .o_close_hold_request(hold), .o_cycle_in_progress(prog), .o_shot_count(shot),
        .o_force_lockout(), .o_permanent_fault(), .o_detector_start(), .o_success(ok),
        .o_shot_success(ss));
    breaker_model breaker_model_inst (.i_clk(clk), .i_rst_b(rst_b), .i_trip(trip), .i_close(ac),
        .o_pole_open(pole));
    // Free-running system clock at 40 MHz.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Success pulses last one cycle, so they are gathered for a later compare.
    always @(posedge clk) begin
        if (ss !== 5'h0) ss_seen <= ss_seen | ss;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize;
        $display("Checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Trip held long enough to pass the input synchronisers.
    task automatic pulse_trip;
        @(posedge clk);
        trip <= 1'b1;
        repeat (4) @(posedge clk);
        trip <= 1'b0;
    endtask
    // Waits for the close pulse and measures its length in clocks.
    // Its first tick may be partial, so the clocks are rounded up to whole ticks.
    task automatic close_len;
        n = 0;
        while (ac !== 1'b1) @(posedge clk);
        chk("hold", 1, {31'h0, hold});
        while (ac === 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk("pulse", ar_pkg::CLOSE_PULSE_MS, (n + TK - 1) / TK);
    endtask
    task automatic end_ok(input logic [4:0] e);
        while (ok !== 1'b1) @(posedge clk);
        chk("shot0", 0, {29'h0, shot});
        chk("prog0", 0, {31'h0, prog});
        chk("ssucc", {27'h0, e}, {27'h0, ss_seen});
    endtask
    // Hang guard, well beyond the roughly 4400 clocks the sequence needs.
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize;
    end
    initial begin
        {psel, penable, pwrite, trip, en, lo, rx, arc, pfi, sci, ld, rst_b} = 12'h0;
        {insvc, sc, hl, tp} = 4'hf;
        fp = 3'h1;
        paddr = 8'h00;
        pwdata = 32'h0;
        ss_seen = 5'h0;
        seed = 32'hd2ab0c07;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, ar_pkg::OFS_CTRL, 32'h0);
        chk("ctrl_rst", 32'h8, rd);
        apb(1'b0, 8'hfc, 32'h0);
        chk("slverr", 1, {31'h0, serr});
        seed = lfsr(seed);
        dead = 2 + int'(seed[1:0]);
        apb(1'b1, ar_pkg::OFS_DEAD3P_BASE, 32'(dead));
        // Reclaim outlasts the close pulse so a retrip after the pulse still falls inside it.
        apb(1'b1, ar_pkg::OFS_RECLAIM, 32'hc8);
        // Dead time starts on an open breaker alone; clear by command allowed.
        apb(1'b1, ar_pkg::OFS_CTRL, 32'h228);
        pulse_trip();
        repeat (10) @(posedge clk);
        chk("refused", 0, {31'h0, prog});
        en <= 1'b1;
        repeat (4) @(posedge clk);
        pulse_trip();
        repeat (6) @(posedge clk);
        chk("shot1", 1, {29'h0, shot});
        chk("prog1", 1, {31'h0, prog});
        close_len();
        end_ok(5'h2);
        apb(1'b1, ar_pkg::OFS_CMD, 32'h1);
        repeat (3) @(posedge clk);
        chk("cleared", 0, {31'h0, ok});
        // Second cycle with a retrip inside the reclaim time.
        ss_seen = 5'h0;
        pulse_trip();
        close_len();
        pulse_trip();
        repeat (6) @(posedge clk);
        chk("hold0", 0, {31'h0, hold});
        chk("shot2", 2, {29'h0, shot});
        close_len();
        // Hold reclaim well past its setting, then let it expire.
        rx <= 1'b1;
        repeat (600) @(posedge clk);
        chk("extend", 1, {31'h0, prog});
        rx <= 1'b0;
        end_ok(5'h4);
        // Skip setting starts at shot two; a lockout then ends the cycle.
        apb(1'b1, ar_pkg::OFS_CTRL, 32'h229);
        pulse_trip();
        repeat (6) @(posedge clk);
        chk("skip", 2, {29'h0, shot});
        lo <= 1'b1;
        repeat (6) @(posedge clk);
        chk("lock0", 0, {29'h0, shot});
        summarize();
    end
endmodule
`default_nettype wire

/* bench/breaker_model.sv */
// Purpose: Behavioural breaker that opens on a trip and closes on autoclose.
// Assumes: All three poles move together; trips are three-phase here.
// Notes: Pole state is registered so the sequencer sees a real breaker delay.
`timescale 1ns/1ps
`default_nettype none
module breaker_model (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_trip,
    input wire logic i_close,
    output logic [2:0] o_pole_open
);
    // A trip wins over a close so a retrip during the pulse reopens the poles.
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) o_pole_open <= 3'h0;
        else if (i_trip) o_pole_open <= 3'h7;
        else if (i_close) o_pole_open <= 3'h0;
    end
endmodule
`default_nettype wire

/* logic/autoreclose_sequencer.sv */
// Purpose: Autoreclose shot sequencing, dead time, autoclose and reclaim for one breaker.
// Assumes: Protection and breaker inputs are asynchronous pins; APB on the system clock.
// Notes: Healthy and synchronism-check timeouts live outside; close waits for healthy, and for synchronism check on three-phase shots only.
`timescale 1ns/1ps
`default_nettype none
module autoreclose_sequencer #(
    parameter int TICK_CYCLES = ar_pkg::TICK_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_prot_trip,
    input wire logic i_ar_enable,
    input wire logic i_cb_in_service,
    input wire logic [2:0] i_pole_open,
    input wire logic i_line_dead,
    input wire logic i_system_check_ok,
    input wire logic i_cb_healthy,
    input wire logic i_lockout,
    input wire logic i_reclaim_extend,
    input wire logic i_three_phase_trip,
    input wire logic [2:0] i_faulted_phase,
    input wire logic i_arc_extinct,
    input wire logic i_permanent_fault,
    input wire logic i_success_clear_input,
    output logic o_autoclose,
    output logic o_close_hold_request,
    output logic o_cycle_in_progress,
    output logic [2:0] o_shot_count,
    output logic o_force_lockout,
    output logic o_permanent_fault,
    output logic o_detector_start,
    output logic o_success,
    output logic [4:0] o_shot_success
);
    localparam int SYNC_W = 18;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic trip_s, en_s, svc_s, ld_s, sys_s, hlt_s, lock_s, ext_s, tp_s, arc_s, perm_s, cin_s;
    logic [2:0] open_s;
    logic [2:0] fph_s;
    logic trip_d_q, en_d_q;
    logic [12:0] ctrl_q;
    logic [15:0] sp_dead_q, reclaim_q, clr_dly_q;
    logic [31:0] sp_lim_q;
    logic [15:0] dead3p_q [4];
    logic [15:0] tick_cnt_q;
    logic tick_q;
    ar_pkg::ar_state_e state_q;
    logic [2:0] shot_q;
    logic [15:0] elapsed_q, pulse_q, clr_cnt_q;
    logic done_q, clr_cmd_q, sp_cycle_q;
    logic acc, wr, setup, hit;
    logic [31:0] rd_mux;

    // Two-stage synchronisers for every pin input.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {i_prot_trip, i_ar_enable, i_cb_in_service, i_pole_open, i_line_dead,
                       i_system_check_ok, i_cb_healthy, i_lockout, i_reclaim_extend,
                       i_three_phase_trip, i_faulted_phase, i_arc_extinct,
                       i_permanent_fault, i_success_clear_input};
            sync_q <= meta_q;
        end
    end
    assign {trip_s, en_s, svc_s, open_s, ld_s, sys_s, hlt_s, lock_s, ext_s, tp_s, fph_s,
            arc_s, perm_s, cin_s} = sync_q;

    // Edge memories for trip and enable.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            trip_d_q <= 1'b0;
            en_d_q <= 1'b0;
        end else begin
            trip_d_q <= trip_s;
            en_d_q <= en_s;
        end
    end

    // Settings fields.
    logic skip, ld_q, bo_q, adapt;
    logic [2:0] max_shots;
    logic [1:0] src;
    assign skip = ctrl_q[ar_pkg::CTRL_SKIP];
    assign max_shots = ctrl_q[ar_pkg::CTRL_MAX_LSB +: 3];
    assign src = ctrl_q[ar_pkg::CTRL_SRC_LSB +: 2];
    assign ld_q = ctrl_q[ar_pkg::CTRL_LD];
    assign bo_q = ctrl_q[ar_pkg::CTRL_BO];
    assign adapt = ctrl_q[ar_pkg::CTRL_ADAPT];

    // APB decode; every access waits one cycle so read data comes from a flop.
    assign setup = i_psel & i_penable & !o_pready;
    assign acc = i_psel & i_penable & o_pready;
    assign wr = acc & i_pwrite & !o_pslverr;
    always_comb begin
        hit = (i_paddr[1:0] == 2'h0);
        rd_mux = 32'h0;
        unique case (i_paddr & 8'hfc)
            ar_pkg::OFS_CTRL: rd_mux = {19'h0, ctrl_q};
            ar_pkg::OFS_CMD: rd_mux = 32'h0;
            ar_pkg::OFS_SP_DEAD: rd_mux = {16'h0, sp_dead_q};
            ar_pkg::OFS_SP_LIMITS: rd_mux = sp_lim_q;
            ar_pkg::OFS_RECLAIM: rd_mux = {16'h0, reclaim_q};
            ar_pkg::OFS_CLEAR_DLY: rd_mux = {16'h0, clr_dly_q};
            ar_pkg::OFS_STATUS: rd_mux = {24'h0, done_q, o_success, o_close_hold_request,
                                          o_cycle_in_progress, 1'b0, shot_q};
            ar_pkg::OFS_DEAD3P_BASE, ar_pkg::OFS_DEAD3P_BASE + 8'h04,
            ar_pkg::OFS_DEAD3P_BASE + 8'h08, ar_pkg::OFS_DEAD3P_BASE + 8'h0c:
                rd_mux = {16'h0, dead3p_q[i_paddr[3:2]]};
            default: hit = 1'b0;
        endcase
    end

    // Bus answer flops.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup & !hit;
            o_prdata <= (setup & hit & !i_pwrite) ? rd_mux : 32'h0;
        end
    end

    // Setting registers; they take effect at the completing edge only.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            ctrl_q <= ar_pkg::CTRL_RST;
            sp_dead_q <= ar_pkg::DEAD_RST;
            sp_lim_q <= ar_pkg::SP_LIMITS_RST;
            reclaim_q <= ar_pkg::RECLAIM_RST;
            clr_dly_q <= ar_pkg::CLEAR_DLY_RST;
        end else if (wr) begin
            unique case (i_paddr)
                ar_pkg::OFS_CTRL: ctrl_q <= i_pwdata[12:0];
                ar_pkg::OFS_SP_DEAD: sp_dead_q <= i_pwdata[15:0];
                ar_pkg::OFS_SP_LIMITS: sp_lim_q <= i_pwdata;
                ar_pkg::OFS_RECLAIM: reclaim_q <= i_pwdata[15:0];
                ar_pkg::OFS_CLEAR_DLY: clr_dly_q <= i_pwdata[15:0];
                default: ;
            endcase
        end
    end

    // One dead time for each of three-phase shots one to four; shots five to seven reuse the first three.
    for (genvar k = 0; k < 4; k++) begin : g_dead
        always_ff @(posedge i_sys_clk) begin
            if (!i_rst_b) begin
                dead3p_q[k] <= ar_pkg::DEAD_RST;
            end else if (wr && i_paddr == ar_pkg::OFS_DEAD3P_BASE + 8'(4 * k)) begin
                dead3p_q[k] <= i_pwdata[15:0];
            end
        end
    end

    // Clear command is a one-cycle pulse from the command word.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            clr_cmd_q <= 1'b0;
        end else begin
            clr_cmd_q <= wr & (i_paddr == ar_pkg::OFS_CMD) & i_pwdata[ar_pkg::CMD_CLEAR];
        end
    end

    // Millisecond tick shared by every timer.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            tick_cnt_q <= 16'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == 16'(TICK_CYCLES - 1));
            // Wrap on the terminal count itself so the tick period is exactly TICK_CYCLES clocks.
            tick_cnt_q <= (tick_cnt_q == 16'(TICK_CYCLES - 1)) ? 16'h0 : tick_cnt_q + 16'h1;
        end
    end

    // Sequencing conditions.
    logic trip_rise, three_p, sp_dead, open_all, closed_all, ph_open, line_ok;
    logic start_ok, fixed_done, adapt_done, sp_done, tp_done, close_ok, init_ok;
    logic [2:0] shot_next, shot_first;
    logic [15:0] sp_min, sp_max, d3p;
    assign trip_rise = trip_s & !trip_d_q;
    assign three_p = sp_cycle_q ? 1'b0 : 1'b1;
    assign sp_dead = (state_q == ar_pkg::ST_DEAD) & !three_p;
    assign open_all = &open_s;
    assign closed_all = ~|open_s;
    assign ph_open = |(open_s & fph_s);
    assign sp_min = sp_lim_q[15:0];
    assign sp_max = sp_lim_q[31:16];
    assign d3p = dead3p_q[2'(shot_q - 3'h1)];
    assign line_ok = !(three_p & ld_q) | ld_s;
    assign shot_next = shot_q + 3'h1;
    assign shot_first = skip ? 3'h2 : 3'h1;
    assign init_ok = trip_rise & en_s & svc_s;
    always_comb begin
        unique case (src)
            ar_pkg::SRC_PROT_OP: start_ok = trip_s & (!ld_q | ld_s);
            ar_pkg::SRC_PROT_RESET: start_ok = !trip_s & (!bo_q | (three_p ? open_all : ph_open))
                                               & line_ok;
            default: start_ok = (three_p ? open_all : ph_open) & line_ok;
        endcase
    end
    // Adaptive path replaces the fixed time by a window closed by arc extinction.
    assign fixed_done = !adapt & (elapsed_q >= sp_dead_q);
    assign adapt_done = adapt & ((elapsed_q >= sp_min & arc_s) | elapsed_q >= sp_max);
    assign sp_done = adapt ? adapt_done : fixed_done;
    assign tp_done = elapsed_q >= d3p;
    assign close_ok = hlt_s & !lock_s & (three_p ? open_all & sys_s : ph_open);

    // Main sequence: state, shot counter, elapsed timer and done flag.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            state_q <= ar_pkg::ST_IDLE;
            shot_q <= 3'h0;
            elapsed_q <= 16'h0;
            done_q <= 1'b0;
            sp_cycle_q <= 1'b0;
            o_force_lockout <= 1'b0;
            o_shot_success <= 5'h0;
        end else begin
            o_force_lockout <= 1'b0;
            o_shot_success <= 5'h0;
            if (tick_q) begin
                elapsed_q <= elapsed_q + 16'h1;
            end
            if (state_q != ar_pkg::ST_IDLE && lock_s) begin
                state_q <= ar_pkg::ST_IDLE;
                shot_q <= 3'h0;
                done_q <= 1'b0;
            end else begin
                unique case (state_q)
                    ar_pkg::ST_IDLE: begin
                        shot_q <= 3'h0;
                        done_q <= 1'b0;
                        if (init_ok && shot_first > max_shots) begin
                            o_force_lockout <= 1'b1;
                        end else if (init_ok) begin
                            shot_q <= shot_first;
                            sp_cycle_q <= !tp_s & !skip;
                            state_q <= ar_pkg::ST_ARMED;
                        end
                    end
                    ar_pkg::ST_ARMED: begin
                        elapsed_q <= 16'h0;
                        if (start_ok) begin
                            state_q <= ar_pkg::ST_DEAD;
                        end
                    end
                    ar_pkg::ST_DEAD: begin
                        if (three_p ? tp_done : sp_done) begin
                            done_q <= 1'b1;
                            state_q <= ar_pkg::ST_CLOSE;
                        end
                    end
                    ar_pkg::ST_CLOSE: begin
                        elapsed_q <= 16'h0;
                        if (close_ok) begin
                            state_q <= ar_pkg::ST_RECLAIM;
                        end
                    end
                    ar_pkg::ST_RECLAIM: begin
                        if (trip_rise) begin
                            done_q <= 1'b0;
                            elapsed_q <= 16'h0;
                            sp_cycle_q <= 1'b0;
                            if (shot_next > max_shots) begin
                                o_force_lockout <= 1'b1;
                                shot_q <= 3'h0;
                                state_q <= ar_pkg::ST_IDLE;
                            end else begin
                                shot_q <= shot_next;
                                state_q <= ar_pkg::ST_ARMED;
                            end
                        end else if (elapsed_q >= reclaim_q && !ext_s) begin
                            state_q <= ar_pkg::ST_IDLE;
                            shot_q <= 3'h0;
                            if (closed_all && !trip_s) begin
                                o_shot_success <= sp_cycle_q ? 5'h01 : 5'(5'h01 << shot_q);
                            end else begin
                                o_force_lockout <= 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Autoclose pulse and close-hold latch.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            pulse_q <= 16'h0;
            o_autoclose <= 1'b0;
            o_close_hold_request <= 1'b0;
        end else begin
            if (state_q == ar_pkg::ST_CLOSE && close_ok && !lock_s) begin
                pulse_q <= ar_pkg::CLOSE_PULSE_TICKS;
                o_autoclose <= 1'b1;
                o_close_hold_request <= 1'b1;
            end else begin
                if (tick_q && pulse_q != 16'h0) begin
                    pulse_q <= pulse_q - 16'h1;
                end
                o_autoclose <= (pulse_q != 16'h0) && !(tick_q && pulse_q == 16'h1);
                if (trip_rise || state_q == ar_pkg::ST_IDLE) begin
                    o_close_hold_request <= 1'b0;
                end
            end
        end
    end

    // Status outputs; the detector runs only inside an adaptive single-pole dead time.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_cycle_in_progress <= 1'b0;
            o_shot_count <= 3'h0;
            o_detector_start <= 1'b0;
            o_permanent_fault <= 1'b0;
        end else begin
            o_cycle_in_progress <= (state_q != ar_pkg::ST_IDLE);
            o_shot_count <= shot_q;
            o_detector_start <= adapt & sp_dead;
            o_permanent_fault <= adapt & sp_dead & perm_s;
        end
    end

    // Success flag; a new success wins over any clear in the same cycle.
    logic clr_any;
    assign clr_any = (ctrl_q[ar_pkg::CTRL_CLR_CMD] & clr_cmd_q)
                   | (ctrl_q[ar_pkg::CTRL_CLR_DIS] & en_d_q & !en_s)
                   | (ctrl_q[ar_pkg::CTRL_CLR_IN] & cin_s)
                   | (ctrl_q[ar_pkg::CTRL_CLR_DLY] & o_success & clr_cnt_q >= clr_dly_q);
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            o_success <= 1'b0;
            clr_cnt_q <= 16'h0;
        end else begin
            if (o_shot_success != 5'h0) begin
                o_success <= 1'b1;
                clr_cnt_q <= 16'h0;
            end else if (clr_any) begin
                o_success <= 1'b0;
            end else if (tick_q && o_success) begin
                clr_cnt_q <= clr_cnt_q + 16'h1;
            end
        end
    end

    // Helper: ticks seen while the autoclose pulse is high.
    logic [15:0] seen_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            seen_q <= 16'h0;
        end else begin
            // A reload restarts the count, so a pulse stretched by a new close is not miscounted.
            seen_q <= (!o_autoclose || (state_q == ar_pkg::ST_CLOSE && close_ok && !lock_s))
                      ? 16'h0 : seen_q + {15'h0, tick_q};
        end
    end

    sequence close_issued;
        $rose(o_autoclose);
    endsequence
    idle_shot_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        state_q == ar_pkg::ST_IDLE |-> shot_q == 3'h0)
        else $error("shot count not zero when idle");
    shot_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        state_q == ar_pkg::ST_RECLAIM && trip_rise && !lock_s && shot_next <= max_shots
        |=> shot_q == $past(shot_q) + 3'h1 && done_q == 1'b0)
        else $error("retrip did not step shot");
    skip_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        state_q == ar_pkg::ST_IDLE && init_ok && skip && max_shots >= 3'h2 |=> shot_q == 3'h2)
        else $error("skip did not start at shot two");
    over_max_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        state_q == ar_pkg::ST_RECLAIM && trip_rise && !lock_s && shot_next > max_shots
        |=> o_force_lockout && state_q == ar_pkg::ST_IDLE)
        else $error("no lockout above max shots");
    success_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        o_shot_success != 5'h0 |-> shot_q == 3'h0 ##1 o_success)
        else $error("success without counter clear");
    pulse_len_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $fell(o_autoclose) |-> $past(seen_q) == ar_pkg::CLOSE_PULSE_TICKS - 16'h1)
        else $error("autoclose pulse length wrong");
    hold_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        close_issued |-> o_close_hold_request && $past(close_ok))
        else $error("close hold missing with pulse");
    extend_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        state_q == ar_pkg::ST_RECLAIM && ext_s && !trip_rise && !lock_s
        |=> state_q == ar_pkg::ST_RECLAIM)
        else $error("reclaim ended while extended");
    detect_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        o_detector_start |-> $past(adapt && sp_dead))
        else $error("detector started outside adaptive dead");
endmodule
`default_nettype wire

/* shared/ar_pkg.sv */
// Purpose: Shared constants and types for the autoreclose sequencer.
// Assumes: 40 MHz system clock, APB register access, millisecond timers.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package ar_pkg;
    // Timing base.
    localparam int SYS_CLK_KHZ = 40000;
    localparam int TICK_PERIOD_MS = 1;
    localparam int TICK_CYCLES = SYS_CLK_KHZ * TICK_PERIOD_MS;
    localparam int CLOSE_PULSE_MS = 100;
    localparam logic [15:0] CLOSE_PULSE_TICKS = 16'(CLOSE_PULSE_MS / TICK_PERIOD_MS);
    // Register offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_SP_DEAD = 8'h08;
    localparam logic [7:0] OFS_SP_LIMITS = 8'h0c;
    localparam logic [7:0] OFS_RECLAIM = 8'h10;
    localparam logic [7:0] OFS_CLEAR_DLY = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_DEAD3P_BASE = 8'h20;
    // Control field positions.
    localparam int CTRL_SKIP = 0;
    localparam int CTRL_MAX_LSB = 1;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_LD = 6;
    localparam int CTRL_BO = 7;
    localparam int CTRL_ADAPT = 8;
    localparam int CTRL_CLR_CMD = 9;
    localparam int CTRL_CLR_DIS = 10;
    localparam int CTRL_CLR_IN = 11;
    localparam int CTRL_CLR_DLY = 12;
    localparam int CMD_CLEAR = 0;
    // Dead-time start sources.
    localparam logic [1:0] SRC_PROT_RESET = 2'h0;
    localparam logic [1:0] SRC_PROT_OP = 2'h1;
    // Reset values.
    localparam logic [12:0] CTRL_RST = 13'h0008;
    localparam logic [15:0] DEAD_RST = 16'h01f4;
    localparam logic [31:0] SP_LIMITS_RST = 32'h03e8_00c8;
    localparam logic [15:0] RECLAIM_RST = 16'h1388;
    localparam logic [15:0] CLEAR_DLY_RST = 16'h2710;
    typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_DEAD, ST_CLOSE, ST_RECLAIM} ar_state_e;
endpackage
